// *** hw/mbd_pkg.sv ***
// Functional notes
// - 0x75 stores immediate to direct, 3B/3cy.
// - 0xF6-F7 store accumulator indirectly, 1B/3cy.
// - 0xA6-A7 direct byte to indirect, 2B/5cy.
// - 0x76-77 immediate to indirect, 2B/3cy.
// - 0x90 loads data_pointer immediate, 3B/3cy.
// - 0x93 code byte at data_pointer+acc, 1B/3cy.
// - 0x83 code byte at pc+acc, 1B/3cy.
// - external reads 0xE2-E3, 0xE0: 1B, 3-10cy.
// - external writes 0xF2-F3, 0xF0: 1B, 4-11cy.
// - push 0xC0 4cy, pop 0xD0 3cy, 2B.
// - swap_with_accumulator bank, direct, indirect forms.
// - 0xD6-D7 swaps low nibbles only, 1B/3cy.
// - 0x73 jumps to data_pointer+acc, 1B/2cy.
// - 0x60/0x70 branch on acc zero/nonzero.
// - 0x40/0x50 branch on carry set/clear.
// - 0x20/0x30 branch on bit set/clear.
// - 0x10 branches on set bit, clears it.
// - compare_jump_unequal branches when operands differ, 3B/4cy.
// - decrement_jump_nonzero decrements, branches when nonzero.
// - clear/set/complement carry and direct bits.
// - carry and_logic/or_logic with bit or complement.
// - 0xA2 bit to carry, 0x92 carry to bit.
package mbd_pkg;

  localparam logic [7:0] OPC_MOV_DIR_IMM = 8'h75;
  localparam logic [7:0] OPC_MOV_IND_A   = 8'hf6;
  localparam logic [7:0] OPC_MOV_IND_DIR = 8'ha6;
  localparam logic [7:0] OPC_MOV_IND_IMM = 8'h76;
  localparam logic [7:0] OPC_LD_DATA_POINTER     = 8'h90;
  localparam logic [7:0] OPC_CODE_DATA_POINTER   = 8'h93;
  localparam logic [7:0] OPC_CODE_PC     = 8'h83;
  localparam logic [7:0] OPC_XRD_IND     = 8'he2;
  localparam logic [7:0] OPC_XRD_DATA_POINTER    = 8'he0;
  localparam logic [7:0] OPC_XWR_IND     = 8'hf2;
  localparam logic [7:0] OPC_XWR_DATA_POINTER    = 8'hf0;
  localparam logic [7:0] OPC_PUSH        = 8'hc0;
  localparam logic [7:0] OPC_POP         = 8'hd0;
  localparam logic [7:0] OPC_XCH_BANK    = 8'hc8;
  localparam logic [7:0] OPC_XCH_DIR     = 8'hc5;
  localparam logic [7:0] OPC_XCH_IND     = 8'hc6;
  localparam logic [7:0] OPC_NIBBLE_SWAP_LOW        = 8'hd6;
  localparam logic [7:0] OPC_JMP_ADPTR   = 8'h73;
  localparam logic [7:0] OPC_JZ          = 8'h60;
  localparam logic [7:0] OPC_JNZ         = 8'h70;
  localparam logic [7:0] OPC_JC          = 8'h40;
  localparam logic [7:0] OPC_JNC         = 8'h50;
  localparam logic [7:0] OPC_JB          = 8'h20;
  localparam logic [7:0] OPC_JNB         = 8'h30;
  localparam logic [7:0] OPC_JBC         = 8'h10;
  localparam logic [7:0] OPC_COMPARE_JUMP_UNEQUAL_DIR    = 8'hb5;
  localparam logic [7:0] OPC_COMPARE_JUMP_UNEQUAL_IMM    = 8'hb4;
  localparam logic [7:0] OPC_COMPARE_JUMP_UNEQUAL_BANK   = 8'hb8;
  localparam logic [7:0] OPC_COMPARE_JUMP_UNEQUAL_IND    = 8'hb6;
  localparam logic [7:0] OPC_DECREMENT_JUMP_NONZERO_BANK   = 8'hd8;
  localparam logic [7:0] OPC_DECREMENT_JUMP_NONZERO_DIR    = 8'hd5;
  localparam logic [7:0] OPC_CLR_C       = 8'hc3;
  localparam logic [7:0] OPC_SET_C       = 8'hd3;
  localparam logic [7:0] OPC_CPL_C       = 8'hb3;
  localparam logic [7:0] OPC_CLR_BIT     = 8'hc2;
  localparam logic [7:0] OPC_SET_BIT     = 8'hd2;
  localparam logic [7:0] OPC_CPL_BIT     = 8'hb2;
  localparam logic [7:0] OPC_ANL_C       = 8'h82;
  localparam logic [7:0] OPC_ANL_CN      = 8'hb0;
  localparam logic [7:0] OPC_ORL_C       = 8'h72;
  localparam logic [7:0] OPC_ORL_CN      = 8'ha0;
  localparam logic [7:0] OPC_MOV_C_BIT   = 8'ha2;
  localparam logic [7:0] OPC_MOV_BIT_C   = 8'h92;

  localparam logic [3:0] XRD_MIN_CYC = 4'h3;
  localparam logic [3:0] XWR_MIN_CYC = 4'h4;

  typedef enum logic [5:0] {
    K_NONE = 6'b000000, K_MOV_DIR_IMM = 6'b000001, K_MOV_IND_A = 6'b000010,
    K_MOV_IND_DIR = 6'b000011, K_MOV_IND_IMM = 6'b000100, K_LD_DATA_POINTER = 6'b000101,
    K_CODE_DATA_POINTER = 6'b000110, K_CODE_PC = 6'b000111, K_XRD = 6'b001000,
    K_XWR = 6'b001001, K_PUSH = 6'b001010, K_POP = 6'b001011,
    K_XCH = 6'b001100, K_NIBBLE_SWAP_LOW = 6'b001101, K_JMP_ADPTR = 6'b001110,
    K_JZ = 6'b001111, K_JNZ = 6'b010000, K_JC = 6'b010001,
    K_JNC = 6'b010010, K_JB = 6'b010011, K_JNB = 6'b010100,
    K_JBC = 6'b010101, K_COMPARE_JUMP_UNEQUAL = 6'b010110, K_DECREMENT_JUMP_NONZERO = 6'b010111,
    K_CLR_C = 6'b011000, K_SET_C = 6'b011001, K_CPL_C = 6'b011010,
    K_CLR_BIT = 6'b011011, K_SET_BIT = 6'b011100, K_CPL_BIT = 6'b011101,
    K_ANL_C = 6'b011110, K_ANL_CN = 6'b011111, K_ORL_C = 6'b100000,
    K_ORL_CN = 6'b100001, K_MOV_C_BIT = 6'b100010, K_MOV_BIT_C = 6'b100011
  } mbd_kind_t;

  // where the byte in mem_val comes from
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_BANK = 3'b001, OP_DIR = 3'b010,
    OP_IND  = 3'b011, OP_IMM  = 3'b100, OP_WIDE = 3'b101
  } mbd_opnd_t;

  typedef struct packed {
    mbd_kind_t  kind;
    mbd_opnd_t  opnd;
    logic [1:0] len;
    logic [3:0] cyc;
    logic       ptr_sel;
    logic [2:0] bank_sel;
  } mbd_dec_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  op1;
    logic [7:0]  op2;
    logic [15:0] pc_next;
    logic [7:0]  acc;
    logic        carry;
    logic [15:0] data_pointer;
    logic [7:0]  mem_val;
    logic        bit_val;
  } mbd_ins_t;

  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  mem;
    logic        carry;
    logic        bit_val;
    logic [15:0] pc;
    logic [15:0] data_pointer;
    logic [15:0] addr;
    logic        taken;
    logic        wr_acc;
    logic        wr_mem;
    logic        wr_carry;
    logic        wr_bit;
    logic        wr_data_pointer;
  } mbd_res_t;

endpackage

// *** hw/mbd_decoder.sv ***
`timescale 1ns/1ps
module mbd_decoder
  import mbd_pkg::*;
#(
  parameter int STRETCH_W = 3
) (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 issue,
  input  wire mbd_ins_t             ins,
  input  wire logic [STRETCH_W-1:0] stretch,
  output logic                      ready,
  output logic                      done,
  output mbd_dec_t                  dec,
  output mbd_res_t                  res
);

  typedef enum logic {S_IDLE = 1'b0, S_BUSY = 1'b1} mbd_state_t;

  function automatic mbd_dec_t ent(input mbd_kind_t k, input mbd_opnd_t o,
                                   input logic [1:0] l, input logic [3:0] c);
    mbd_dec_t d;
    d          = '0;
    d.kind     = k;
    d.opnd     = o;
    d.len      = l;
    d.cyc      = c;
    return d;
  endfunction

  mbd_dec_t   dec_c;
  mbd_res_t   res_c;
  logic [7:0] base2;
  logic [7:0] base8;
  logic [3:0] xstr;

  assign base2 = {ins.opcode[7:1], 1'b0};
  assign base8 = {ins.opcode[7:3], 3'b000};
  assign xstr  = 4'(stretch);

  always_comb begin
    dec_c = ent(K_NONE, OP_NONE, 2'h1, 4'h1);
    case (ins.opcode)
      OPC_MOV_DIR_IMM: dec_c = ent(K_MOV_DIR_IMM, OP_IMM, 2'h3, 4'h3);
      OPC_LD_DATA_POINTER:     dec_c = ent(K_LD_DATA_POINTER, OP_IMM, 2'h3, 4'h3);
      OPC_CODE_DATA_POINTER:   dec_c = ent(K_CODE_DATA_POINTER, OP_NONE, 2'h1, 4'h3);
      OPC_CODE_PC:     dec_c = ent(K_CODE_PC, OP_NONE, 2'h1, 4'h3);
      OPC_XRD_DATA_POINTER:    dec_c = ent(K_XRD, OP_WIDE, 2'h1, XRD_MIN_CYC + xstr);
      OPC_XWR_DATA_POINTER:    dec_c = ent(K_XWR, OP_WIDE, 2'h1, XWR_MIN_CYC + xstr);
      OPC_PUSH:        dec_c = ent(K_PUSH, OP_DIR, 2'h2, 4'h4);
      OPC_POP:         dec_c = ent(K_POP, OP_DIR, 2'h2, 4'h3);
      OPC_XCH_DIR:     dec_c = ent(K_XCH, OP_DIR, 2'h2, 4'h3);
      OPC_JMP_ADPTR:   dec_c = ent(K_JMP_ADPTR, OP_NONE, 2'h1, 4'h2);
      OPC_JZ:          dec_c = ent(K_JZ, OP_NONE, 2'h2, 4'h3);
      OPC_JNZ:         dec_c = ent(K_JNZ, OP_NONE, 2'h2, 4'h3);
      OPC_JC:          dec_c = ent(K_JC, OP_NONE, 2'h2, 4'h3);
      OPC_JNC:         dec_c = ent(K_JNC, OP_NONE, 2'h2, 4'h3);
      OPC_JB:          dec_c = ent(K_JB, OP_NONE, 2'h3, 4'h4);
      OPC_JNB:         dec_c = ent(K_JNB, OP_NONE, 2'h3, 4'h4);
      OPC_JBC:         dec_c = ent(K_JBC, OP_NONE, 2'h3, 4'h4);
      OPC_COMPARE_JUMP_UNEQUAL_DIR:    dec_c = ent(K_COMPARE_JUMP_UNEQUAL, OP_DIR, 2'h3, 4'h4);
      OPC_COMPARE_JUMP_UNEQUAL_IMM:    dec_c = ent(K_COMPARE_JUMP_UNEQUAL, OP_IMM, 2'h3, 4'h4);
      OPC_DECREMENT_JUMP_NONZERO_DIR:    dec_c = ent(K_DECREMENT_JUMP_NONZERO, OP_DIR, 2'h3, 4'h4);
      OPC_CLR_C:       dec_c = ent(K_CLR_C, OP_NONE, 2'h1, 4'h1);
      OPC_SET_C:       dec_c = ent(K_SET_C, OP_NONE, 2'h1, 4'h1);
      OPC_CPL_C:       dec_c = ent(K_CPL_C, OP_NONE, 2'h1, 4'h1);
      OPC_CLR_BIT:     dec_c = ent(K_CLR_BIT, OP_NONE, 2'h2, 4'h3);
      OPC_SET_BIT:     dec_c = ent(K_SET_BIT, OP_NONE, 2'h2, 4'h3);
      OPC_CPL_BIT:     dec_c = ent(K_CPL_BIT, OP_NONE, 2'h2, 4'h3);
      OPC_ANL_C:       dec_c = ent(K_ANL_C, OP_NONE, 2'h2, 4'h2);
      OPC_ANL_CN:      dec_c = ent(K_ANL_CN, OP_NONE, 2'h2, 4'h2);
      OPC_ORL_C:       dec_c = ent(K_ORL_C, OP_NONE, 2'h2, 4'h2);
      OPC_ORL_CN:      dec_c = ent(K_ORL_CN, OP_NONE, 2'h2, 4'h2);
      OPC_MOV_C_BIT:   dec_c = ent(K_MOV_C_BIT, OP_NONE, 2'h2, 4'h2);
      OPC_MOV_BIT_C:   dec_c = ent(K_MOV_BIT_C, OP_NONE, 2'h2, 4'h3);
      default: begin
        case (base2)
          OPC_MOV_IND_A:   dec_c = ent(K_MOV_IND_A, OP_IND, 2'h1, 4'h3);
          OPC_MOV_IND_DIR: dec_c = ent(K_MOV_IND_DIR, OP_DIR, 2'h2, 4'h5);
          OPC_MOV_IND_IMM: dec_c = ent(K_MOV_IND_IMM, OP_IMM, 2'h2, 4'h3);
          OPC_XRD_IND:     dec_c = ent(K_XRD, OP_IND, 2'h1, XRD_MIN_CYC + xstr);
          OPC_XWR_IND:     dec_c = ent(K_XWR, OP_IND, 2'h1, XWR_MIN_CYC + xstr);
          OPC_XCH_IND:     dec_c = ent(K_XCH, OP_IND, 2'h1, 4'h3);
          OPC_NIBBLE_SWAP_LOW:        dec_c = ent(K_NIBBLE_SWAP_LOW, OP_IND, 2'h1, 4'h3);
          OPC_COMPARE_JUMP_UNEQUAL_IND:    dec_c = ent(K_COMPARE_JUMP_UNEQUAL, OP_IND, 2'h3, 4'h4);
          default: begin
            case (base8)
              OPC_XCH_BANK:  dec_c = ent(K_XCH, OP_BANK, 2'h1, 4'h2);
              OPC_COMPARE_JUMP_UNEQUAL_BANK: dec_c = ent(K_COMPARE_JUMP_UNEQUAL, OP_BANK, 2'h3, 4'h4);
              OPC_DECREMENT_JUMP_NONZERO_BANK: dec_c = ent(K_DECREMENT_JUMP_NONZERO, OP_BANK, 2'h2, 4'h3);
              default:       dec_c = ent(K_NONE, OP_NONE, 2'h1, 4'h1);
            endcase
          end
        endcase
      end
    endcase
    dec_c.ptr_sel  = ins.opcode[0];
    dec_c.bank_sel = ins.opcode[2:0];
  end

  logic [7:0]  rel;
  logic [15:0] rel_tgt;
  logic [7:0]  cmp_a;
  logic [7:0]  cmp_b;
  logic [7:0]  dec_val;

  // offset is the last operand byte; signed, from the following instruction
  assign rel     = (dec_c.len == 2'h3) ? ins.op2 : ins.op1;
  assign rel_tgt = ins.pc_next + {{8{rel[7]}}, rel};
  assign cmp_a   = (dec_c.opnd == OP_IND || dec_c.opnd == OP_BANK) ? ins.mem_val : ins.acc;
  assign cmp_b   = (dec_c.opnd == OP_DIR) ? ins.mem_val : ins.op1;
  assign dec_val = ins.mem_val - 8'h01;

  always_comb begin
    res_c       = '0;
    res_c.acc   = ins.acc;
    res_c.mem   = ins.mem_val;
    res_c.carry = ins.carry;
    res_c.pc    = ins.pc_next;
    res_c.data_pointer  = ins.data_pointer;
    unique case (dec_c.kind)
      K_MOV_DIR_IMM: begin
        res_c.mem    = ins.op2;
        res_c.wr_mem = 1'b1;
      end
      K_MOV_IND_A: begin
        res_c.mem    = ins.acc;
        res_c.wr_mem = 1'b1;
      end
      K_MOV_IND_DIR, K_PUSH, K_POP: res_c.wr_mem = 1'b1;
      K_MOV_IND_IMM: begin
        res_c.mem    = ins.op1;
        res_c.wr_mem = 1'b1;
      end
      K_LD_DATA_POINTER: begin
        res_c.data_pointer    = {ins.op1, ins.op2};
        res_c.wr_data_pointer = 1'b1;
      end
      K_CODE_DATA_POINTER: begin
        res_c.addr   = ins.data_pointer + {8'h00, ins.acc};
        res_c.wr_acc = 1'b1;
      end
      K_CODE_PC: begin
        res_c.addr   = ins.pc_next + {8'h00, ins.acc};
        res_c.wr_acc = 1'b1;
      end
      K_XRD: begin
        res_c.addr   = (dec_c.opnd == OP_WIDE) ? ins.data_pointer : {8'h00, ins.mem_val};
        res_c.wr_acc = 1'b1;
      end
      K_XWR: begin
        res_c.addr   = (dec_c.opnd == OP_WIDE) ? ins.data_pointer : {8'h00, ins.mem_val};
        res_c.mem    = ins.acc;
        res_c.wr_mem = 1'b1;
      end
      K_XCH: begin
        res_c.acc    = ins.mem_val;
        res_c.mem    = ins.acc;
        res_c.wr_acc = 1'b1;
        res_c.wr_mem = 1'b1;
      end
      K_NIBBLE_SWAP_LOW: begin
        res_c.acc    = {ins.acc[7:4], ins.mem_val[3:0]};
        res_c.mem    = {ins.mem_val[7:4], ins.acc[3:0]};
        res_c.wr_acc = 1'b1;
        res_c.wr_mem = 1'b1;
      end
      K_JMP_ADPTR: begin
        res_c.pc    = ins.data_pointer + {8'h00, ins.acc};
        res_c.taken = 1'b1;
      end
      K_JZ:  res_c.taken = (ins.acc == 8'h00);
      K_JNZ: res_c.taken = (ins.acc != 8'h00);
      K_JC:  res_c.taken = ins.carry;
      K_JNC: res_c.taken = !ins.carry;
      K_JB:  res_c.taken = ins.bit_val;
      K_JNB: res_c.taken = !ins.bit_val;
      K_JBC: begin
        res_c.taken   = ins.bit_val;
        res_c.wr_bit  = ins.bit_val;
        res_c.bit_val = 1'b0;
      end
      K_COMPARE_JUMP_UNEQUAL: begin
        res_c.taken    = (cmp_a != cmp_b);
        res_c.carry    = (cmp_a < cmp_b);
        res_c.wr_carry = 1'b1;
      end
      K_DECREMENT_JUMP_NONZERO: begin
        res_c.mem    = dec_val;
        res_c.wr_mem = 1'b1;
        res_c.taken  = (dec_val != 8'h00);
      end
      K_CLR_C, K_SET_C, K_CPL_C: begin
        res_c.carry    = (dec_c.kind == K_SET_C) | ((dec_c.kind == K_CPL_C) & !ins.carry);
        res_c.wr_carry = 1'b1;
      end
      K_CLR_BIT, K_SET_BIT, K_CPL_BIT: begin
        res_c.bit_val = (dec_c.kind == K_SET_BIT) | ((dec_c.kind == K_CPL_BIT) & !ins.bit_val);
        res_c.wr_bit  = 1'b1;
      end
      K_ANL_C, K_ANL_CN, K_ORL_C, K_ORL_CN: begin
        res_c.wr_carry = 1'b1;
        case (dec_c.kind)
          K_ANL_C:  res_c.carry = ins.carry & ins.bit_val;
          K_ANL_CN: res_c.carry = ins.carry & !ins.bit_val;
          K_ORL_C:  res_c.carry = ins.carry | ins.bit_val;
          default:  res_c.carry = ins.carry | !ins.bit_val;
        endcase
      end
      K_MOV_C_BIT: begin
        res_c.carry    = ins.bit_val;
        res_c.wr_carry = 1'b1;
      end
      K_MOV_BIT_C: begin
        res_c.bit_val = ins.carry;
        res_c.wr_bit  = 1'b1;
      end
      K_NONE: res_c.taken = 1'b0;
    endcase
    if (res_c.taken && dec_c.kind != K_JMP_ADPTR) begin
      res_c.pc = rel_tgt;
    end
  end

  mbd_state_t state_q;
  mbd_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  mbd_dec_t   dec_q;
  mbd_dec_t   dec_d;
  mbd_res_t   res_q;
  mbd_res_t   res_d;

  assign ready = (state_q == S_IDLE);
  assign done  = (state_q == S_BUSY) && (cnt_q == 4'h0);
  assign dec   = dec_q;
  assign res   = res_q;

  // busy for exactly the decoded cycle count; stretch widens external moves
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    dec_d   = dec_q;
    res_d   = res_q;
    unique case (state_q)
      S_IDLE: begin
        if (issue) begin
          state_d = S_BUSY;
          cnt_d   = dec_c.cyc - 4'h1;
          dec_d   = dec_c;
          res_d   = res_c;
        end
      end
      S_BUSY: begin
        if (cnt_q == 4'h0) begin
          state_d = S_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      cnt_q   <= 4'h0;
      dec_q   <= '0;
      res_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      dec_q   <= dec_d;
      res_q   <= res_d;
    end
  end

endmodule

// *** dv/mbd_mem_model.sv ***
`timescale 1ns/1ps
// internal data memory seen by the core: byte store plus bit store
module mbd_mem_model
  import mbd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] op1,
  input  wire logic       done,
  input  wire mbd_res_t   res,
  output logic [7:0]      mem_val,
  output logic            bit_val
);
  logic [7:0]   ram [256];
  logic [255:0] bits_q;

  initial begin
    for (int i = 0; i < 256; i++) begin
      ram[i] = 8'(i) ^ 8'h3c;
    end
  end

  // pair forms go through a pointer register, eight-wide forms hit a bank register
  always_comb begin
    case (opcode[3:0])
      4'h6, 4'h7: mem_val = ram[ram[{7'h00, opcode[0]}]];
      4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: mem_val = ram[{5'h00, opcode[2:0]}];
      default: mem_val = ram[op1];
    endcase
    // external moves through a pointer register hand over the pointer itself
    if (opcode[7:5] == 3'h7 && opcode[3:1] == 3'h1) begin
      mem_val = ram[{7'h00, opcode[0]}];
    end
    bit_val = bits_q[op1];
  end

  // odd bit addresses start set; bit write-backs land when the instruction ends
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bits_q <= {128{2'b10}};
    end else if (done && res.wr_bit) begin
      bits_q[op1] <= res.bit_val;
    end
  end
endmodule

// *** dv/mbd_decoder_monitor.sv ***
`timescale 1ns/1ps
module mbd_decoder_monitor
  import mbd_pkg::*;
#(
  parameter int STRETCH_W = 3
) (
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire logic                 issue,
  input wire mbd_ins_t             ins,
  input wire logic [STRETCH_W-1:0] stretch,
  input wire logic                 ready,
  input wire logic                 done,
  input wire mbd_dec_t             dec,
  input wire mbd_res_t             res
);
  logic [3:0]           cnt_q, cnt_d;
  mbd_ins_t             ins_q, ins_d;
  logic [STRETCH_W-1:0] str_q, str_d;

  // cycles since the taking edge, and the request as taken
  always_comb begin
    cnt_d = cnt_q;
    ins_d = ins_q;
    str_d = str_q;
    if (issue && ready) begin
      cnt_d = 4'h1;
      ins_d = ins;
      str_d = stretch;
    end else if (!ready && !done) begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
      ins_q <= '0;
      str_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      ins_q <= ins_d;
      str_q <= str_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_take;
    issue && ready;
  endsequence
  sequence s_take_op(logic [7:0] op);
    issue && ready && ins.opcode == op;
  endsequence

  property p_busy; s_take |=> !ready; endproperty
  a_busy: assert property (p_busy) else $error("ready high right after a taken issue");
  property p_done_at_cyc; !ready |-> (done == (cnt_q == dec.cyc)); endproperty
  a_done_at_cyc: assert property (p_done_at_cyc) else $error("done not in cycle dec.cyc");
  property p_done_bound; s_take |-> ##[1:11] done; endproperty
  a_done_bound: assert property (p_done_bound) else $error("no done within 11 cycles");
  property p_ready_back; done |=> ready; endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready not back after done");
  property p_sel; s_take |=> dec.ptr_sel == ins_q.opcode[0] && dec.bank_sel == ins_q.opcode[2:0]; endproperty
  a_sel: assert property (p_sel) else $error("pointer or bank select wrong");
  property p_xrd; s_take_op(8'he0) |=> dec.cyc == XRD_MIN_CYC + 4'(str_q); endproperty
  a_xrd: assert property (p_xrd) else $error("external read cycle count wrong");
  property p_xwr; s_take_op(8'hf0) |=> dec.cyc == XWR_MIN_CYC + 4'(str_q); endproperty
  a_xwr: assert property (p_xwr) else $error("external write cycle count wrong");
  property p_jz; s_take_op(8'h60) |=> res.taken == (ins_q.acc == 8'h00); endproperty
  a_jz: assert property (p_jz) else $error("zero branch decision wrong");
  property p_rel;
    s_take_op(8'h40) |=> res.pc == (ins_q.carry ? ins_q.pc_next + {{8{ins_q.op1[7]}}, ins_q.op1} : ins_q.pc_next);
  endproperty
  a_rel: assert property (p_rel) else $error("carry branch target wrong");
  property p_jbc; s_take_op(8'h10) |=> res.wr_bit == ins_q.bit_val && (!res.wr_bit || !res.bit_val); endproperty
  a_jbc: assert property (p_jbc) else $error("bit clear on branch wrong");
  property p_hold; !ready && !done |=> $stable(dec) && $stable(res); endproperty
  a_hold: assert property (p_hold) else $error("results moved while busy");
endmodule

bind mbd_decoder mbd_decoder_monitor #(.STRETCH_W(STRETCH_W)) i_mon (
  .clk(clk), .arst_n(arst_n), .issue(issue), .ins(ins), .stretch(stretch),
  .ready(ready), .done(done), .dec(dec), .res(res)
);

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import mbd_pkg::*;
  logic       clk, arst_n, issue, ready, done, m_bit;
  logic [2:0] stretch;
  logic [7:0] m_val;
  mbd_ins_t   req, ins_w;
  mbd_dec_t   dec;
  mbd_res_t   res;
  int         error_cnt, checks_done, cyc_cnt, n;
  // opcode, stretch, length, cycles
  logic [19:0] rows [55] = '{20'h75033, 20'hf6013, 20'hf7013, 20'ha6025, 20'ha7025, 20'h76023, 20'h77023,
    20'h90033, 20'h93013, 20'h83013, 20'he2013, 20'he3215, 20'he071a, 20'hf2014, 20'hf3519, 20'hf071b,
    20'hc0024, 20'hd0023, 20'hc8012, 20'hcf012, 20'hc5023, 20'hc6013, 20'hc7013, 20'hd6013, 20'hd7013,
    20'h73012, 20'h60023, 20'h70023, 20'h40023, 20'h50023, 20'h20034, 20'h30034, 20'h10034, 20'hb5034,
    20'hb4034, 20'hb8034, 20'hbf034, 20'hb6034, 20'hb7034, 20'hd8023, 20'hdf023, 20'hd5034, 20'hc3011,
    20'hd3011, 20'hb3011, 20'hc2023, 20'hd2023, 20'hb2023, 20'h82022, 20'hb0022, 20'h72022, 20'ha0022,
    20'ha2022, 20'h92023, 20'ha5011};

  always_comb begin
    ins_w = req;
    ins_w.mem_val = m_val;
    ins_w.bit_val = m_bit;
  end

  mbd_decoder #(.STRETCH_W(3)) i_dut (.clk(clk), .arst_n(arst_n), .issue(issue), .ins(ins_w),
    .stretch(stretch), .ready(ready), .done(done), .dec(dec), .res(res));
  mbd_mem_model i_mem (.clk(clk), .arst_n(arst_n), .opcode(req.opcode), .op1(req.op1), .done(done),
    .res(res), .mem_val(m_val), .bit_val(m_bit));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one instruction; returns the cycle in which done showed
  task automatic run(input logic [7:0] op, a1, a2, ac, input logic cy, input logic [2:0] st);
    @(posedge clk);
    issue <= 1'b1;
    req.opcode <= op;
    req.op1 <= a1;
    req.op2 <= a2;
    req.acc <= ac;
    req.carry <= cy;
    stretch <= st;
    @(posedge clk);
    issue <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask

  // et/ec: bit 1 says whether to compare taken/carry
  task automatic tc(input logic [7:0] op, a1, a2, ac, input logic cy, input logic [1:0] et, ec,
                    input logic [15:0] pc);
    run(op, a1, a2, ac, cy, 3'h0);
    if (et[1]) chk("taken", 16'(res.taken), 16'(et[0]));
    if (ec[1]) chk("carry", 16'(res.carry), 16'(ec[0]));
    chk("pc", res.pc, pc);
  endtask

  initial begin
    arst_n = 1'b0;
    issue = 1'b0;
    stretch = 3'h0;
    req = '0;
    req.pc_next = 16'h1000;
    req.data_pointer = 16'h1000;
    error_cnt = 0;
    checks_done = 0;
    cyc_cnt = 0;
    repeat (8) @(posedge clk);
    chk("reset_ready", 16'(ready), 16'h0001);
    chk("reset_dec", 16'(dec), 16'h0000);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i][19:12], 8'h05, 8'h06, 8'h00, 1'b0, rows[i][10:8]);
      chk("len", 16'(dec.len), 16'(rows[i][7:4]));
      chk("cyc", 16'(dec.cyc), 16'(rows[i][3:0]));
      chk("done_cycle", 16'(n), 16'(rows[i][3:0]));
    end
    tc(8'h60, 8'h80, 8'h00, 8'h00, 1'b0, 2'b11, 2'b00, 16'h0f80);
    tc(8'h70, 8'h10, 8'h00, 8'h00, 1'b0, 2'b10, 2'b00, 16'h1000);
    tc(8'h50, 8'h7f, 8'h00, 8'h00, 1'b0, 2'b11, 2'b00, 16'h107f);
    tc(8'h40, 8'hfc, 8'h00, 8'h00, 1'b1, 2'b11, 2'b00, 16'h0ffc);
    tc(8'h20, 8'h03, 8'h10, 8'h00, 1'b0, 2'b11, 2'b00, 16'h1010);
    tc(8'h10, 8'h07, 8'hfe, 8'h00, 1'b0, 2'b11, 2'b00, 16'h0ffe);
    tc(8'h20, 8'h07, 8'hfe, 8'h00, 1'b0, 2'b10, 2'b00, 16'h1000);
    tc(8'h30, 8'h07, 8'hfe, 8'h00, 1'b0, 2'b11, 2'b00, 16'h0ffe);
    tc(8'hb4, 8'h20, 8'hf0, 8'h10, 1'b0, 2'b11, 2'b11, 16'h0ff0);
    tc(8'hb4, 8'h20, 8'hf0, 8'h20, 1'b1, 2'b10, 2'b10, 16'h1000);
    tc(8'hd9, 8'h04, 8'h00, 8'h00, 1'b0, 2'b11, 2'b00, 16'h1004);
    chk("decrement_jump_nonzero_mem", 16'(res.mem), 16'h003c);
    tc(8'hd5, 8'h3d, 8'h08, 8'h00, 1'b0, 2'b10, 2'b00, 16'h1000);
    tc(8'h73, 8'h00, 8'h00, 8'h10, 1'b0, 2'b00, 2'b00, 16'h1010);
    tc(8'hc3, 8'h00, 8'h00, 8'h00, 1'b1, 2'b00, 2'b10, 16'h1000);
    tc(8'hd3, 8'h00, 8'h00, 8'h00, 1'b0, 2'b00, 2'b11, 16'h1000);
    tc(8'hb3, 8'h00, 8'h00, 8'h00, 1'b1, 2'b00, 2'b10, 16'h1000);
    tc(8'h82, 8'h03, 8'h00, 8'h00, 1'b1, 2'b00, 2'b11, 16'h1000);
    tc(8'hb0, 8'h03, 8'h00, 8'h00, 1'b1, 2'b00, 2'b10, 16'h1000);
    tc(8'h72, 8'h02, 8'h00, 8'h00, 1'b0, 2'b00, 2'b10, 16'h1000);
    tc(8'ha0, 8'h02, 8'h00, 8'h00, 1'b0, 2'b00, 2'b11, 16'h1000);
    tc(8'ha2, 8'h03, 8'h00, 8'h00, 1'b0, 2'b00, 2'b11, 16'h1000);
    run(8'h90, 8'h12, 8'h34, 8'h00, 1'b0, 3'h0);
    chk("data_pointer", res.data_pointer, 16'h1234);
    run(8'hd7, 8'h00, 8'h00, 8'ha5, 1'b0, 3'h0);
    chk("nib_acc", 16'(res.acc), 16'h00a1);
    chk("nib_mem", 16'(res.mem), 16'h0005);
    run(8'hc5, 8'h40, 8'h00, 8'h11, 1'b0, 3'h0);
    chk("swap_acc", 16'(res.acc), 16'h007c);
    chk("swap_mem", 16'(res.mem), 16'h0011);
    run(8'h75, 8'h30, 8'h99, 8'h00, 1'b0, 3'h0);
    chk("imm_mem", {7'h00, res.wr_mem, res.mem}, 16'h0199);
    run(8'h77, 8'h55, 8'h00, 8'h00, 1'b0, 3'h0);
    chk("ind_imm", {7'h00, res.wr_mem, res.mem}, 16'h0155);
    run(8'hf6, 8'h00, 8'h00, 8'h42, 1'b0, 3'h0);
    chk("ind_acc", {7'h00, res.wr_mem, res.mem}, 16'h0142);
    run(8'h93, 8'h00, 8'h00, 8'h10, 1'b0, 3'h0);
    chk("code_data_pointer", res.addr, 16'h1010);
    run(8'h83, 8'h00, 8'h00, 8'h20, 1'b0, 3'h0);
    chk("code_pc", res.addr, 16'h1020);
    run(8'he3, 8'h00, 8'h00, 8'h00, 1'b0, 3'h0);
    chk("xrd_addr", res.addr, 16'h003d);
    run(8'hf0, 8'h00, 8'h00, 8'h5a, 1'b0, 3'h0);
    chk("xwr_addr", res.addr, 16'h1000);
    chk("xwr_mem", {7'h00, res.wr_mem, res.mem}, 16'h015a);
    // a request held high while busy must not restart the instruction
    @(posedge clk);
    issue <= 1'b1;
    req.opcode <= 8'ha6;
    @(posedge clk);
    req.opcode <= 8'hc3;
    repeat (2) @(negedge clk);
    chk("busy_ignored", 16'(dec.cyc), 16'h0005);
    @(posedge clk);
    issue <= 1'b0;
    repeat (8) @(negedge clk);
    // reset in mid-instruction, with issue still high
    run(8'he0, 8'h00, 8'h00, 8'h00, 1'b0, 3'h7);
    @(posedge clk);
    issue <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("midrst_busy", 16'(ready), 16'h0000);
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    chk("midrst_ready", 16'({ready, done}), 16'h0002);
    chk("midrst_dec", 16'(dec), 16'h0000);
    @(posedge clk);
    issue <= 1'b0;
    arst_n <= 1'b1;
    run(8'hf2, 8'h00, 8'h00, 8'h00, 1'b0, 3'h3);
    chk("after_rst_cyc", 16'(n), 16'h0007);
    end_sim();
  end
endmodule
